// ---- logic/apdu_counter.sv ----
`timescale 1ns/1ps
`include "apdu_regs.svh"
module apdu_counter
  import apdu_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic addr_strobe,
  input wire logic port_e_bit_seven,
  input wire logic device_clock_input,
  apdu_ctl_if.cnt_mp ctl
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic src_q;
  logic strobe_q;
  wire src_lvl = ctl.clk_sel ? device_clock_input : port_e_bit_seven;
  wire tick = src_lvl & ~src_q;
  wire moved = addr_strobe ^ strobe_q;
  wire idle = (addr_strobe == ctl.idle_pol);
  wire full = (cnt == `APDU_CNT_FULL);

  // Saturating at full holds the count at 15 once powered down
  always_comb begin
    next_cnt = cnt;
    if (!ctl.apd_on || moved || !idle) begin
      next_cnt = `APDU_CNT_ZERO;
    end else if (tick && !full) begin
      next_cnt = cnt + `APDU_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt <= `APDU_CNT_ZERO;
      src_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      src_q <= src_lvl;
      strobe_q <= addr_strobe;
    end
  end

  assign ctl.cnt = cnt;
  // Exit is combinational so the first strobe edge already wakes the part
  assign ctl.pd = full & ctl.apd_on & idle & ~moved;
endmodule

// ---- logic/apdu_ctl_if.sv ----
`timescale 1ns/1ps
interface apdu_ctl_if;
  logic apd_on;
  logic idle_pol;
  logic clk_sel;
  logic saver;
  logic bus8;
  logic [3:0] cnt;
  logic pd;

  modport top_mp (output apd_on, idle_pol, clk_sel, saver, bus8,
                  input cnt, pd);
  modport cnt_mp (input apd_on, idle_pol, clk_sel, output cnt, pd);
  modport mem_mp (input saver, bus8);
endinterface

// ---- logic/apdu_mem_gate.sv ----
`timescale 1ns/1ps
module apdu_mem_gate
  import apdu_pkg::*;
(
  input wire logic chip_sel_n,
  input wire logic code_sel,
  input wire logic sram_sel,
  input wire logic addr_lsb,
  apdu_ctl_if.mem_mp ctl,
  output logic code_mem_active,
  output logic [1:0] code_half_en,
  output logic [1:0] sram_half_en
);
  wire halve = ctl.saver & ctl.bus8;
  wire [1:0] half_sel = halve ? {addr_lsb, ~addr_lsb} : 2'h3;
  wire code_on = ~chip_sel_n & (~ctl.saver | code_sel);
  wire sram_on = ~chip_sel_n & sram_sel;

  assign code_mem_active = code_on;
  // With the saver off the idle code memory keeps both halves lit
  assign code_half_en = code_on ? (code_sel ? half_sel : 2'h3) : 2'h0;
  assign sram_half_en = sram_on ? half_sel : 2'h0;
endmodule

// ---- logic/apdu_pkg.sv ----
package apdu_pkg;

  typedef enum logic [2:0] {
    APDU_ST_RUN = 3'b001,
    APDU_ST_PDOWN = 3'b010,
    APDU_ST_SLEEP = 3'b100
  } apdu_state_t;

endpackage

// ---- logic/apdu_regs.svh ----
`ifndef APDU_REGS_SVH
`define APDU_REGS_SVH

`define APDU_CTRL0_OFS 8'hB0
`define APDU_CTRL1_OFS 8'hB1
`define APDU_STAT_OFS 8'hB2

`define APDU_CTRL0_RST 8'h00
`define APDU_CTRL1_RST 2'h0
`define APDU_RD_ZERO 8'h00

`define APDU_C0_RUN 0
`define APDU_C0_POL 1
`define APDU_C0_EN 2
`define APDU_C0_SAVER 3
`define APDU_C0_TURBO 4
`define APDU_C0_ACLK 5
`define APDU_C0_RCLK 6
`define APDU_C0_TMR 7

`define APDU_C1_CLKSEL 0
`define APDU_C1_SLEEP 1
`define APDU_C1_MSB 1

`define APDU_CNT_ZERO 4'h0
`define APDU_CNT_ONE 4'h1
`define APDU_CNT_FULL 4'hF

`endif

// ---- logic/apdu_top.sv ----
// What this block does
// - Chip select is active low; high forces power-down at once.
// - Chip select inactive shuts bus buffers to the logic array.
// - Enabled and idle strobe: 4-bit counter overflows after 15 clocks.
// - Strobe pulsing again leaves power-down or sleep immediately.
// - Ctrl1 bit 0 picks counter clock: 0 port pin, 1 clock input.
// - Ctrl0 bit 1 is idle polarity; count only at that steady level.
// - Ctrl0 bit 2 enables auto power-down only with bit 0 also set; clear means no counting.
// - Sleep needs sleep, enable, polarity bits set and overflow.
// - Logic array keeps watching and answering inputs during sleep.
// - Ctrl1 bit 1 enables sleep mode.
// - Ctrl0 bit 4 set lets the array power down when inputs idle.
// - Ctrl0 bit 5 cuts array clock; else clock edges wake array.
// - Ctrl0 bit 6 cuts the clock to the macrocell registers.
// - Ctrl0 bit 3 is current saver, reset clear; clear keeps memory on.
// - Chip select high puts code memory in standby regardless.
// - Saver on: code memory standby whenever not selected.
// - Saver on with 8-bit bus enables only one memory half.
`timescale 1ns/1ps
`include "apdu_regs.svh"
module apdu_top
  import apdu_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic chip_sel_n,
  input wire logic addr_strobe,
  input wire logic port_e_bit_seven,
  input wire logic device_clock_input,
  input wire logic array_inputs_changing,
  input wire logic bus_width_8,
  input wire logic code_sel,
  input wire logic sram_sel,
  input wire logic addr_lsb,
  output logic power_down_signal,
  output logic power_down_mode,
  output logic sleep_mode,
  output logic bus_buffer_en,
  output logic array_powered,
  output logic array_input_live,
  output logic array_clock_gate,
  output logic macrocell_clock_gate,
  output logic timer_clock_gate,
  output logic clock_buffer_en,
  output logic code_mem_active,
  output logic [1:0] code_half_en,
  output logic [1:0] sram_half_en
);
  logic [7:0] power_mode_ctrl0;
  logic [`APDU_C1_MSB:0] power_mode_ctrl1;
  logic [7:0] next_rdata;
  logic clk_q;
  apdu_state_t state;
  apdu_state_t next_state;
  logic [2:0] state_code;

  apdu_ctl_if ctl ();

  // Register decode
  wire wr_c0 = reg_wr && (reg_addr == `APDU_CTRL0_OFS);
  wire wr_c1 = reg_wr && (reg_addr == `APDU_CTRL1_OFS);
  wire rd_c0 = reg_addr == `APDU_CTRL0_OFS;
  wire rd_c1 = reg_addr == `APDU_CTRL1_OFS;
  wire rd_st = reg_addr == `APDU_STAT_OFS;

  // Control fields
  wire apd_run = power_mode_ctrl0[`APDU_C0_RUN];
  wire power_down_enable_bit = power_mode_ctrl0[`APDU_C0_EN];
  wire idle_pol = power_mode_ctrl0[`APDU_C0_POL];
  wire saver_on = power_mode_ctrl0[`APDU_C0_SAVER];
  wire turbo_off = power_mode_ctrl0[`APDU_C0_TURBO];
  wire aclk_off = power_mode_ctrl0[`APDU_C0_ACLK];
  wire rclk_off = power_mode_ctrl0[`APDU_C0_RCLK];
  wire tmr_off = power_mode_ctrl0[`APDU_C0_TMR];
  wire clk_sel = power_mode_ctrl1[`APDU_C1_CLKSEL];
  wire sleep_en = power_mode_ctrl1[`APDU_C1_SLEEP];

  assign ctl.apd_on = power_down_enable_bit & apd_run;
  assign ctl.idle_pol = idle_pol;
  assign ctl.clk_sel = clk_sel;
  assign ctl.saver = saver_on;
  assign ctl.bus8 = bus_width_8;

  apdu_counter u_counter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .addr_strobe(addr_strobe),
    .port_e_bit_seven(port_e_bit_seven),
    .device_clock_input(device_clock_input),
    .ctl(ctl.cnt_mp)
  );

  apdu_mem_gate u_mem (
    .chip_sel_n(chip_sel_n),
    .code_sel(code_sel),
    .sram_sel(sram_sel),
    .addr_lsb(addr_lsb),
    .ctl(ctl.mem_mp),
    .code_mem_active(code_mem_active),
    .code_half_en(code_half_en),
    .sram_half_en(sram_half_en)
  );

  // Power modes
  wire pd = ctl.pd;
  wire sleep_now = pd & sleep_en & power_down_enable_bit & idle_pol;
  wire clk_edge = device_clock_input ^ clk_q;

  assign power_down_signal = pd;
  assign sleep_mode = sleep_now;
  assign power_down_mode = chip_sel_n | pd;
  assign bus_buffer_en = ~chip_sel_n;
  // Array path ignores sleep on purpose so it keeps answering its pins
  assign array_input_live = 1'b1;
  assign array_powered = ~turbo_off | array_inputs_changing
    | (~aclk_off & clk_edge);
  assign array_clock_gate = ~aclk_off;
  assign macrocell_clock_gate = ~rclk_off;
  assign timer_clock_gate = ~tmr_off;
  assign clock_buffer_en = ~(aclk_off & rclk_off & tmr_off & pd);

  always_comb begin
    next_state = APDU_ST_RUN;
    if (sleep_now) begin
      next_state = APDU_ST_SLEEP;
    end else if (pd || chip_sel_n) begin
      next_state = APDU_ST_PDOWN;
    end
  end

  always_comb begin
    unique case (state)
      APDU_ST_RUN: state_code = 3'h0;
      APDU_ST_PDOWN: state_code = 3'h1;
      APDU_ST_SLEEP: state_code = 3'h2;
      default: state_code = 3'h7;
    endcase
  end

  // Unmapped addresses read zero; reserved ctrl1 bits are not stored
  always_comb begin
    next_rdata = `APDU_RD_ZERO;
    if (reg_rd && rd_c0) begin
      next_rdata = power_mode_ctrl0;
    end else if (reg_rd && rd_c1) begin
      next_rdata = {6'h00, power_mode_ctrl1};
    end else if (reg_rd && rd_st) begin
      next_rdata = {state_code, pd, ctl.cnt};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      power_mode_ctrl0 <= `APDU_CTRL0_RST;
      power_mode_ctrl1 <= `APDU_CTRL1_RST;
      reg_rdata <= `APDU_RD_ZERO;
      clk_q <= 1'b0;
      state <= APDU_ST_RUN;
    end else begin
      if (wr_c0) begin
        power_mode_ctrl0 <= reg_wdata;
      end
      if (wr_c1) begin
        power_mode_ctrl1 <= reg_wdata[`APDU_C1_MSB:0];
      end
      reg_rdata <= next_rdata;
      clk_q <= device_clock_input;
      state <= next_state;
    end
  end

  // Checking helpers
  logic strobe_h;
  logic src_h;
  logic [4:0] ticks_h;
  wire src_lvl_h = clk_sel ? device_clock_input : port_e_bit_seven;
  wire tick_h = src_lvl_h & ~src_h;
  wire idle_h = (addr_strobe == idle_pol) && (addr_strobe == strobe_h);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strobe_h <= 1'b0;
      src_h <= 1'b0;
      ticks_h <= 5'h00;
    end else begin
      strobe_h <= addr_strobe;
      src_h <= src_lvl_h;
      if (!ctl.apd_on || !idle_h) begin
        ticks_h <= 5'h00;
      end else if (tick_h && ticks_h != 5'h1F) begin
        ticks_h <= ticks_h + 5'h01;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence strobe_moves;
    addr_strobe != $past(addr_strobe);
  endsequence

  sequence held_idle;
    (ctl.apd_on && (addr_strobe == idle_pol)) [*2];
  endsequence

  cs_forces_pd_a: assert property (
    chip_sel_n |-> power_down_mode && !code_mem_active)
    else $error("chip select high without power-down");

  bus_buf_off_a: assert property (
    bus_buffer_en == !chip_sel_n)
    else $error("bus buffers wrong for chip select");

  overflow_at_15_a: assert property (
    power_down_signal |-> ticks_h >= 5'h0F)
    else $error("power-down before 15 counter clocks");

  overflow_taken_a: assert property (
    held_idle ##0 (ticks_h >= 5'h10) |-> power_down_signal)
    else $error("no power-down after overflow");

  strobe_wakes_a: assert property (
    strobe_moves |-> !power_down_signal ##1 !power_down_signal)
    else $error("strobe edge did not wake device");

  clk_src_reset_a: assert property (
    $past(sys_rst) |-> !clk_sel && !saver_on)
    else $error("clock source or saver not reset");

  polarity_hold_a: assert property (
    power_down_signal |-> addr_strobe == idle_pol)
    else $error("power-down at wrong strobe level");

  disabled_no_cnt_a: assert property (
    !power_down_enable_bit |=> ctl.cnt == 4'h0 && !power_down_signal)
    else $error("counter runs while disabled");

  sleep_cond_a: assert property (
    sleep_mode |-> power_down_signal && sleep_en && power_down_enable_bit && idle_pol)
    else $error("sleep without its conditions");

  sleep_enable_a: assert property (
    (power_down_signal && sleep_en && idle_pol) |-> sleep_mode)
    else $error("sleep not entered");

  turbo_on_a: assert property (
    !turbo_off |-> array_powered)
    else $error("array off with turbo on");

  saver_off_mem_a: assert property (
    (!saver_on && !chip_sel_n) |-> code_mem_active)
    else $error("code memory idle with saver off");

  saver_standby_a: assert property (
    (saver_on && !code_sel) |-> !code_mem_active)
    else $error("code memory on while not selected");

  edge_clears_a: assert property (
    strobe_moves |=> ctl.cnt == 4'h0)
    else $error("counter not cleared by strobe edge");

  ctrl0_write_a: assert property (
    wr_c0 |=> macrocell_clock_gate == !$past(reg_wdata[`APDU_C0_RCLK]))
    else $error("macrocell gate does not follow write");

  cs_low_run_a: assert property (
    (!chip_sel_n && !power_down_signal) |-> !power_down_mode)
    else $error("power-down mode with chip selected and no overflow");

  en_off_pd_a: assert property (
    !power_down_enable_bit |-> !power_down_signal)
    else $error("power-down while auto power-down disabled");

  nonidle_clear_a: assert property (
    (addr_strobe != idle_pol) |=> ctl.cnt == 4'h0)
    else $error("counter kept at busy strobe level");

  cnt_step_a: assert property (
    (ctl.cnt != $past(ctl.cnt))
      |-> (ctl.cnt == 4'h0 || ctl.cnt == $past(ctl.cnt) + 4'h1))
    else $error("counter moved by more than one");

  cnt_hold_full_a: assert property (
    (ctl.cnt == 4'hF && ctl.apd_on && addr_strobe == idle_pol
      && addr_strobe == $past(addr_strobe)) |=> ctl.cnt == 4'hF)
    else $error("full counter did not hold");

  sleep_exit_a: assert property (
    strobe_moves |-> !sleep_mode)
    else $error("sleep kept after strobe edge");

  mode_exit_a: assert property (
    (addr_strobe != $past(addr_strobe) && !chip_sel_n) |-> !power_down_mode)
    else $error("power-down kept after strobe edge");

  sleep_off_a: assert property (
    !sleep_en |-> !sleep_mode)
    else $error("sleep while sleep disabled");

  sleep_live_a: assert property (
    sleep_mode |-> array_input_live)
    else $error("array stopped watching inputs in sleep");

  sleep_entry_a: assert property (
    (power_down_signal && sleep_en && power_down_enable_bit) |-> sleep_mode == idle_pol)
    else $error("sleep does not follow polarity bit");

  aclk_write_a: assert property (
    wr_c0 |=> array_clock_gate == !$past(reg_wdata[`APDU_C0_ACLK]))
    else $error("array clock gate does not follow write");

  clk_wakes_a: assert property (
    (!aclk_off && device_clock_input != $past(device_clock_input))
      |-> array_powered)
    else $error("clock change did not power the array");

  turbo_idle_a: assert property (
    (turbo_off && !array_inputs_changing
      && device_clock_input == $past(device_clock_input))
      |-> !array_powered)
    else $error("array powered with turbo off and quiet inputs");

  cs_code_off_a: assert property (
    chip_sel_n |-> code_half_en == 2'h0)
    else $error("code memory halves lit without chip select");

  code_half_a: assert property (
    (saver_on && bus_width_8 && code_sel && !chip_sel_n)
      |-> $onehot(code_half_en))
    else $error("code memory not halved");

  sram_half_a: assert property (
    (saver_on && bus_width_8 && sram_sel && !chip_sel_n)
      |-> $onehot(sram_half_en))
    else $error("sram not halved");

  clksel_write_a: assert property (
    wr_c1 |=> clk_sel == $past(reg_wdata[`APDU_C1_CLKSEL]))
    else $error("counter clock select does not follow write");

  sleep_write_a: assert property (
    wr_c1 |=> sleep_en == $past(reg_wdata[`APDU_C1_SLEEP]))
    else $error("sleep enable does not follow write");

  saver_write_a: assert property (
    wr_c0 |=> saver_on == $past(reg_wdata[`APDU_C0_SAVER]))
    else $error("current saver does not follow write");
endmodule

// ---- verif/apdu_host_model.sv ----
`timescale 1ns/1ps
module apdu_host_model (
  input wire logic core_clk,
  input wire logic pulse,
  input wire logic idle_lvl,
  input wire logic tick_pe,
  input wire logic tick_ck,
  output logic addr_strobe,
  output logic port_e_bit_seven,
  output logic device_clock_input
);
  initial begin
    addr_strobe = 1'b0;
    port_e_bit_seven = 1'b0;
    device_clock_input = 1'b0;
  end
  // Pulsing toggles every cycle, so gaps stay far below 15 counts
  always @(posedge core_clk) begin
    addr_strobe <= pulse ? ~addr_strobe : idle_lvl;
    port_e_bit_seven <= tick_pe ? ~port_e_bit_seven : 1'b0;
    device_clock_input <= tick_ck ? ~device_clock_input : 1'b0;
  end
endmodule

// ---- verif/apdu_top_test.sv ----
`timescale 1ns/1ps
module apdu_top_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic chip_sel_n = 1'b1;
  logic changing = 1'b0;
  logic bus8 = 1'b0;
  logic code_sel = 1'b0;
  logic sram_sel = 1'b0;
  logic lsb = 1'b0;
  logic pulse = 1'b1;
  logic lvl = 1'b0;
  logic tp = 1'b0;
  logic tc = 1'b0;
  logic stb, pe7, dci, pd, pdm, slp, bbe, apw, ail, acg, mcg, tcg, cbe, cma;
  logic [1:0] che, she;
  int checks = 0;
  int mismatches = 0;
  always #4 core_clk = ~core_clk;
  apdu_host_model u_apdu_host_model (.core_clk(core_clk), .pulse(pulse),
    .idle_lvl(lvl), .tick_pe(tp), .tick_ck(tc), .addr_strobe(stb),
    .port_e_bit_seven(pe7), .device_clock_input(dci));
  apdu_top u_apdu_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_sel_n(chip_sel_n),
    .addr_strobe(stb), .port_e_bit_seven(pe7), .device_clock_input(dci),
    .array_inputs_changing(changing), .bus_width_8(bus8),
    .code_sel(code_sel), .sram_sel(sram_sel), .addr_lsb(lsb),
    .power_down_signal(pd), .power_down_mode(pdm), .sleep_mode(slp),
    .bus_buffer_en(bbe), .array_powered(apw), .array_input_live(ail),
    .array_clock_gate(acg), .macrocell_clock_gate(mcg),
    .timer_clock_gate(tcg), .clock_buffer_en(cbe),
    .code_mem_active(cma), .code_half_en(che), .sram_half_en(she));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    chk8(what, {7'h00, e}, {7'h00, g});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk8("rdata", e, reg_rdata);
  endtask
  // Bounded wait; a hang ends the run instead of stalling it
  task automatic wait_pd(input logic e);
    for (int i = 0; i < 60 && pd !== e; i++) idle(1);
    chk1("pd", e, pd);
    if (pd !== e) complete_run();
  endtask
  task automatic t_reset();
    rd(8'hB0, 8'h00);
    rd(8'hB1, 8'h00);
    rd(8'h5A, 8'h00);
    chk1("pdm", 1'b1, pdm);
    chk1("bbe", 1'b0, bbe);
    chk1("cma", 1'b0, cma);
    @(posedge core_clk) chip_sel_n <= 1'b0;
    idle(1);
    chk1("pdm", 1'b0, pdm);
    chk1("bbe", 1'b1, bbe);
  endtask
  task automatic t_count();
    lvl <= 1'b1;
    wr(8'hB1, 8'h00);
    wr(8'hB0, 8'h87);
    pulse <= 1'b0;
    idle(3);
    // 28 toggles give exactly 14 rising counter clocks
    tp <= 1'b1;
    idle(28);
    tp <= 1'b0;
    idle(3);
    chk1("pd", 1'b0, pd);
    rd(8'hB2, 8'h0E);
    tp <= 1'b1;
    idle(2);
    tp <= 1'b0;
    idle(3);
    wait_pd(1'b1);
    rd(8'hB2, 8'h3F);
    chk1("pdm", 1'b1, pdm);
    chk1("slp", 1'b0, slp);
    pulse <= 1'b1;
    idle(1);
    chk1("pd", 1'b0, pd);
    rd(8'hB2, 8'h00);
    tp <= 1'b1;
  endtask
  task automatic t_pol_en();
    wr(8'hB0, 8'h85);
    pulse <= 1'b0;
    idle(40);
    chk1("pd", 1'b0, pd);
    @(posedge core_clk) lvl <= 1'b0;
    wait_pd(1'b1);
    @(posedge core_clk) pulse <= 1'b1;
    wait_pd(1'b0);
    wr(8'hB0, 8'h81);
    pulse <= 1'b0;
    idle(40);
    chk1("pd", 1'b0, pd);
    rd(8'hB2, 8'h00);
    pulse <= 1'b1;
  endtask
  task automatic t_clksel();
    wr(8'hB0, 8'h87);
    lvl <= 1'b1;
    wr(8'hB1, 8'h01);
    pulse <= 1'b0;
    idle(40);
    chk1("pd", 1'b0, pd);
    @(posedge core_clk) tc <= 1'b1;
    wait_pd(1'b1);
    @(posedge core_clk) pulse <= 1'b1;
    wait_pd(1'b0);
  endtask
  task automatic t_sleep();
    wr(8'hB1, 8'h02);
    pulse <= 1'b0;
    wait_pd(1'b1);
    chk1("slp", 1'b1, slp);
    chk1("ail", 1'b1, ail);
    @(posedge core_clk) pulse <= 1'b1;
    idle(1);
    chk1("slp", 1'b0, slp);
    wr(8'hB0, 8'h85);
    lvl <= 1'b0;
    pulse <= 1'b0;
    wait_pd(1'b1);
    chk1("slp", 1'b0, slp);
    @(posedge core_clk) pulse <= 1'b1;
    wait_pd(1'b0);
  endtask
  task automatic t_gates();
    wr(8'hB0, 8'hE7);
    lvl <= 1'b1;
    pulse <= 1'b0;
    wait_pd(1'b1);
    chk1("acg", 1'b0, acg);
    chk1("mcg", 1'b0, mcg);
    chk1("tcg", 1'b0, tcg);
    chk1("cbe", 1'b0, cbe);
    @(posedge core_clk) pulse <= 1'b1;
    wait_pd(1'b0);
    chk1("cbe", 1'b1, cbe);
    wr(8'hB0, 8'h10);
    tc <= 1'b0;
    idle(3);
    chk1("apw", 1'b0, apw);
    @(posedge core_clk) changing <= 1'b1;
    idle(1);
    chk1("apw", 1'b1, apw);
    @(posedge core_clk) changing <= 1'b0;
    tc <= 1'b1;
    idle(2);
    chk1("apw", 1'b1, apw);
    wr(8'hB0, 8'h00);
    tc <= 1'b0;
    idle(1);
    chk1("apw", 1'b1, apw);
    chk1("mcg", 1'b1, mcg);
  endtask
  task automatic t_mem();
    @(posedge core_clk) sram_sel <= 1'b1;
    idle(1);
    chk1("cma", 1'b1, cma);
    wr(8'hB0, 8'h08);
    idle(1);
    chk1("cma", 1'b0, cma);
    chk8("che", 8'h00, {6'h00, che});
    @(posedge core_clk) bus8 <= 1'b1;
    lsb <= 1'b1;
    idle(1);
    chk8("she", 8'h02, {6'h00, she});
    @(posedge core_clk) sram_sel <= 1'b0;
    code_sel <= 1'b1;
    lsb <= 1'b0;
    idle(1);
    chk8("che", 8'h01, {6'h00, che});
    @(posedge core_clk) chip_sel_n <= 1'b1;
    idle(1);
    chk1("cma", 1'b0, cma);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_count();
    t_pol_en();
    t_clksel();
    t_sleep();
    t_gates();
    t_mem();
    complete_run();
  end
endmodule
